// ---- olps_pkg.sv ----
// olps_pkg: shared constants and carriers for the offload low-pass subsampler
// assumes one frame-synchronous clock domain; no software-visible registers
package olps_pkg;
	localparam int OLPS_WORD_W = 18;
	localparam int OLPS_FIFO_DEPTH = 8;
	localparam int OLPS_PERIOD_W = 16;
	localparam logic [17:0] OLPS_STATE_RESET = 18'h00000;
	localparam logic [17:0] OLPS_COEF_RESET = 18'h00000;
	localparam logic [15:0] OLPS_PERIOD_RESET = 16'h0000;

	typedef logic signed [OLPS_WORD_W-1:0] olps_word_t;

	// parameter set staged by the supervisory side
	typedef struct packed {
		logic [17:0] coef;
		logic [15:0] period;
	} olps_param_s;

	// one offload word leaving through the fifo
	typedef struct packed {
		logic periodic;
		logic [17:0] state;
	} olps_offload_s;

	typedef enum logic [2:0] {
		OLPS_IDLE = 3'b001,
		OLPS_LOAD = 3'b010,
		OLPS_PUSH = 3'b100
	} olps_push_e;
endpackage

// ---- olps_fifo.sv ----
// olps_fifo: parameterised valid/ready fifo
// assumes a single clock; full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module olps_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	wire logic do_wr;
	wire logic do_rd;

	assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
	assign rd_valid_out = (count_q != '0);
	assign rd_data_out = mem_q[rd_ptr_q];
	assign do_wr = wr_valid_in & wr_ready_out;
	assign do_rd = rd_valid_out & rd_ready_in;

	function automatic logic [AW-1:0] olps_inc(input logic [AW-1:0] p);
		olps_inc = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
	endfunction

	always_ff @(posedge sys_clk_in) begin
		if (do_wr) begin
			mem_q[wr_ptr_q] <= wr_data_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (do_wr) wr_ptr_q <= olps_inc(wr_ptr_q);
			if (do_rd) rd_ptr_q <= olps_inc(rd_ptr_q);
			count_q <= count_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule
`default_nettype wire

// ---- olps_top.sv ----
// olps_top: one-pole low-pass filter on a per-frame variable, with offload fifo
// assumes sample_valid pulses once per frame at most; coef is unsigned q0.18
// assumes all controls are single-cycle pulses synchronous to sys_clk_in
// assumes the offload reader follows valid/ready; the fifo head stands until taken
`timescale 1ns/1ps
`default_nettype none
module olps_top
#(
	parameter int FIFO_DEPTH = olps_pkg::OLPS_FIFO_DEPTH
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic frame_start_in,
	input wire logic sample_valid_in,
	input wire logic [olps_pkg::OLPS_WORD_W-1:0] sample_in,
	input wire olps_pkg::olps_param_s param_in,
	input wire logic param_load_in,
	input wire logic offload_req_in,
	output logic telem_valid_out,
	output logic [olps_pkg::OLPS_WORD_W-1:0] telem_data_out,
	output logic [olps_pkg::OLPS_WORD_W-1:0] state_out,
	output var olps_pkg::olps_offload_s offload_out,
	output logic offload_valid_out,
	input wire logic offload_ready_in,
	output logic req_ready_out
);
	import olps_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// parameters: a staged copy written by the supervisor and a live copy read
	// by the filter and the offload timer; the live copy moves only on frame start
	// coef and period always switch together, so a frame never sees a mixed set
	olps_param_s staged_q;
	olps_param_s live_q;
	logic pending_q;
	wire logic param_switch;

	// a load in the same cycle as frame start waits one frame: never a mix
	assign param_switch = frame_start_in && pending_q;

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			staged_q <= '{coef: OLPS_COEF_RESET, period: OLPS_PERIOD_RESET};
		end else if (param_load_in) begin
			staged_q <= param_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			live_q <= '{coef: OLPS_COEF_RESET, period: OLPS_PERIOD_RESET};
		end else if (param_switch) begin
			live_q <= staged_q;
		end
	end

	// set wins: a load beside a frame start is kept for the following one
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pending_q <= 1'b0;
		end else if (param_load_in) begin
			pending_q <= 1'b1;
		end else if (frame_start_in) begin
			pending_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// filter: state + (1-b)(x-state) == b*state + (1-b)*x, one multiply
	// 1-b is formed modulo 2^18, so coef 0 freezes the state instead of
	// passing samples through; the supervisor must keep coef above zero
	// the result lies between old state and sample, so the clamp is only a guard
	// and not a path that legal arithmetic takes
	olps_word_t state_q;
	wire logic [17:0] one_minus_b;
	wire logic signed [19:0] diff;
	wire logic signed [38:0] prod;
	wire logic signed [19:0] next_wide;
	wire logic signed [17:0] next_state;

	assign one_minus_b = 18'h00000 - live_q.coef;
	assign diff = 20'(signed'(sample_in)) - 20'(state_q);
	assign prod = 39'(diff) * 39'(signed'({1'b0, one_minus_b}));
	assign next_wide = 20'(state_q) + 20'(prod >>> 18);

	function automatic olps_word_t olps_sat(input logic signed [19:0] v);
		if (v > 20'sh1ffff) olps_sat = 18'h1ffff;
		else if (v < -20'sh20000) olps_sat = 18'h20000;
		else olps_sat = v[17:0];
	endfunction

	assign next_state = olps_sat(next_wide);

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q <= OLPS_STATE_RESET;
		end else if (sample_valid_in) begin
			// without a sample in this frame the state simply holds
			state_q <= next_state;
		end
	end
	assign state_out = state_q;

	////////////////////////////////////////////////////////////////////////
	// full-rate telemetry passthrough, registered
	// one cycle late and never filtered: the recording path sees every frame raw
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			telem_valid_out <= 1'b0;
			telem_data_out <= '0;
		end else begin
			telem_valid_out <= sample_valid_in;
			telem_data_out <= sample_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// offload trigger: request or periodic frame count (period 0 = off)
	// a request and a periodic hit pending together share one word
	logic [15:0] frame_cnt_q;
	logic req_pend_q;
	logic per_pend_q;
	olps_push_e push_q;
	olps_offload_s push_word_q;
	wire logic period_hit;
	wire logic fifo_wr_ready;
	wire logic push_fire;
	wire logic in_load;
	wire logic in_push;

	assign in_load = (push_q == OLPS_LOAD);
	assign in_push = (push_q == OLPS_PUSH);
	assign period_hit = frame_start_in && (live_q.period != '0)
		&& (frame_cnt_q == live_q.period - 16'h0001);
	assign push_fire = in_push && fifo_wr_ready;
	// a request is held until its word is latched; with the fifo full the latched
	// word waits, and a further request then stays pending with req_ready low
	assign req_ready_out = !req_pend_q;

	// the count restarts when new parameters go live, so a shorter period
	// never finds the counter already past its end
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			frame_cnt_q <= '0;
		end else if (frame_start_in) begin
			frame_cnt_q <= (period_hit || param_switch) ? '0 : frame_cnt_q + 16'h0001;
		end
	end

	// set wins over clear on both pending flags
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			req_pend_q <= 1'b0;
		end else if (offload_req_in) begin
			req_pend_q <= 1'b1;
		end else if (in_load) begin
			req_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			per_pend_q <= 1'b0;
		end else if (period_hit) begin
			per_pend_q <= 1'b1;
		end else if (in_load) begin
			per_pend_q <= 1'b0;
		end
	end

	// the word is latched once and then waits in place for room in the fifo
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			push_word_q <= '0;
		end else if (in_load) begin
			push_word_q <= '{periodic: !req_pend_q, state: state_q};
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			push_q <= OLPS_IDLE;
		end else begin
			case (push_q)
				OLPS_IDLE: begin
					if (req_pend_q || per_pend_q) push_q <= OLPS_LOAD;
				end
				OLPS_LOAD: begin
					push_q <= OLPS_PUSH;
				end
				OLPS_PUSH: begin
					if (fifo_wr_ready) push_q <= OLPS_IDLE;
				end
				default: push_q <= OLPS_IDLE;
			endcase
		end
	end

	// eight words let the supervisor read in bursts without losing offloads;
	// a slower reader delays words; periodic hits that come while one is still pending merge into one word
	olps_fifo #(
		.WIDTH($bits(olps_offload_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.wr_data_in(push_word_q),
		.wr_valid_in(push_fire),
		.wr_ready_out(fifo_wr_ready),
		.rd_data_out(offload_out),
		.rd_valid_out(offload_valid_out),
		.rd_ready_in(offload_ready_in)
	);
endmodule
`default_nettype wire

// ---- olps_top_monitor.sv ----
// olps_top_monitor: port checks on olps_top
// assumes one clock and an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module olps_top_monitor (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic sample_valid_in,
	input wire logic [17:0] sample_in,
	input wire logic offload_req_in,
	input wire logic telem_valid_out,
	input wire logic [17:0] telem_data_out,
	input wire logic [17:0] state_out,
	input wire logic offload_valid_out,
	input wire logic req_ready_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	a_telem_echo: assert property (sample_valid_in |=>
		telem_valid_out && telem_data_out == $past(sample_in)) else $error("bad echo");
	a_telem_quiet: assert property (!sample_valid_in |=> !telem_valid_out)
		else $error("stray telemetry");
	a_state_hold: assert property (!sample_valid_in |=> $stable(state_out))
		else $error("state moved");
	a_fixed_point: assert property (sample_valid_in && sample_in == state_out |=>
		$stable(state_out)) else $error("fixed point moved");
	a_req_taken: assert property (offload_req_in |=> !req_ready_out)
		else $error("request ignored");
	a_offload_due: assert property (offload_req_in && req_ready_out &&
		!offload_valid_out |-> ##[1:6] offload_valid_out) else $error("no offload");
endmodule
bind olps_top olps_top_monitor mon_u (
	.sys_clk_in(sys_clk_in),
	.nrst_in(nrst_in),
	.sample_valid_in(sample_valid_in),
	.sample_in(sample_in),
	.offload_req_in(offload_req_in),
	.telem_valid_out(telem_valid_out),
	.telem_data_out(telem_data_out),
	.state_out(state_out),
	.offload_valid_out(offload_valid_out),
	.req_ready_out(req_ready_out)
);
`default_nettype wire

// ---- olps_consumer.sv ----
// olps_consumer: supervisory reader of offload words
// assumes valid/ready transfer at the rising edge
`timescale 1ns/1ps
`default_nettype none
module olps_consumer (
	input wire logic stall_in,
	output logic ready_out
);
	// stalls only on the bench's command, to back the fifo up
	assign ready_out = !stall_in;
endmodule
`default_nettype wire

// ---- tb_offload_lowpass_subsampler.sv ----
// tb_offload_lowpass_subsampler: scenario bench for olps_top
// assumes the bound monitor and olps_consumer on the offload side
`timescale 1ns/1ps
`default_nettype none
module tb_offload_lowpass_subsampler;
	import olps_pkg::*;
	logic sys_clk_in, nrst_in, frame_start_in, sample_valid_in, param_load_in, offload_req_in;
	logic offload_ready_in, telem_valid_out, offload_valid_out, req_ready_out, stall;
	logic [17:0] sample_in, telem_data_out, state_out, s;
	olps_param_s param_in;
	olps_offload_s offload_out;
	int n_mismatch, n_checks;
	olps_top dut_u (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.frame_start_in(frame_start_in),
		.sample_valid_in(sample_valid_in),
		.sample_in(sample_in),
		.param_in(param_in),
		.param_load_in(param_load_in),
		.offload_req_in(offload_req_in),
		.telem_valid_out(telem_valid_out),
		.telem_data_out(telem_data_out),
		.state_out(state_out),
		.offload_out(offload_out),
		.offload_valid_out(offload_valid_out),
		.offload_ready_in(offload_ready_in),
		.req_ready_out(req_ready_out)
	);
	olps_consumer cons_u (.stall_in(stall), .ready_out(offload_ready_in));
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	////////////////////////////////////////////////////////////////
	task cyc;
		@(posedge sys_clk_in);
		#1;
	endtask
	task chk(input logic [18:0] g, input logic [18:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task w(input bit v);
		for (int i = 0; !(v ? offload_valid_out : req_ready_out); i++) begin
			if (i > 40) begin
				n_mismatch++;
				$display("FAIL t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
				report_and_stop;
			end
			cyc;
		end
	endtask
	// wide signed arithmetic so the expectation never wraps
	function automatic logic [17:0] nx(logic [17:0] c, logic [17:0] v);
		longint d;
		d = (longint'($signed(v)) - longint'($signed(s))) * (64'sd262144 - longint'(c));
		return 18'(longint'($signed(s)) + (d >>> 18));
	endfunction
	task pulse(input logic [2:0] m);
		{frame_start_in, param_load_in, offload_req_in} = m;
		cyc;
		{frame_start_in, param_load_in, offload_req_in} = 3'h0;
	endtask
	task smp(input logic [17:0] c, input logic [17:0] v, input bit k);
		if (sample_valid_in !== 1'b1) sample_valid_in = 1'b1;
		sample_in = v;
		s = nx(c, v);
		cyc;
		if (!k) sample_valid_in = 1'b0;
		chk(state_out, s);
		chk({telem_valid_out, telem_data_out}, {1'b1, v});
	endtask
	////////////////////////////////////////////////////////////////
	task t_filter;
		chk({req_ready_out, state_out}, {1'b1, 18'h0});
		param_in = '{18'h20000, 16'h0};
		pulse(3'h2);
		cyc;
		pulse(3'h4);
		smp(18'h20000, 18'h01000, 1);
		smp(18'h20000, 18'h01000, 0);
		cyc;
		smp(18'h20000, 18'h3f000, 0);
		repeat (3) cyc;
		chk(state_out, s);
	endtask
	task t_param;
		param_in = '{18'h30000, 16'h0};
		pulse(3'h2);
		smp(18'h20000, 18'h02000, 0);
		cyc;
		pulse(3'h4);
		smp(18'h30000, 18'h02000, 0);
	endtask
	task t_offload;
		stall = 1'b1;
		// eight words fill the fifo, a ninth waits latched, a tenth stays pending
		for (int k = 0; k < 10; k++) begin
			pulse(3'h1);
			if (k < 9) w(1'b0);
		end
		repeat (4) cyc;
		chk(req_ready_out, 1'b0);
		stall = 1'b0;
		for (int k = 0; k < 10; k++) begin
			w(1'b1);
			chk(offload_out, {1'b0, s});
			cyc;
		end
		chk({offload_valid_out, req_ready_out}, 2'h1);
	endtask
	task t_periodic;
		stall = 1'b1;
		param_in = '{18'h31d7e, 16'h2};
		pulse(3'h2);
		repeat (4) begin
			cyc;
			pulse(3'h4);
		end
		w(1'b1);
		chk(offload_out, {1'b1, s});
		stall = 1'b0;
	endtask
	initial begin
		n_mismatch = 0;
		n_checks = 0;
		nrst_in = 1'b0;
		stall = 1'b0;
		s = 18'h0;
		sample_in = 18'h0;
		sample_valid_in = 1'b0;
		param_in = '0;
		{frame_start_in, param_load_in, offload_req_in} = 3'h0;
		repeat (10) cyc;
		nrst_in = 1'b1;
		t_filter;
		t_param;
		t_offload;
		t_periodic;
		report_and_stop;
	end
endmodule
`default_nettype wire
